// >>> logic/mosc_consts.vh
/*
  shared constants for the mote operating state control block:
  state codes, fuse table geometry, timing counts.
  assumes a 125 MHz system clock; included by bare name.
*/
`ifndef MOSC_CONSTS_VH
`define MOSC_CONSTS_VH

// system clock period in ns
`define MOSC_CLK_PERIOD_NS 8
// fuse table page size in bytes (one 2 KB flash page)
`define MOSC_FUSE_BYTES 2048
// fuse table word address width (32-bit words, 512 words)
`define MOSC_FUSE_AW 9
// hardware configuration structure: first word index
`define MOSC_FUSE_HW_BASE 9'h000
// design-specific parameter structure: first word index
`define MOSC_FUSE_DS_BASE 9'h100
// io direction word index inside hardware structure
`define MOSC_FUSE_IODIR_IDX 9'h000
// design parameter words kept (uart mode, clock source, trim)
`define MOSC_FUSE_UART_IDX 9'h100
`define MOSC_FUSE_CLKSRC_IDX 9'h101
`define MOSC_FUSE_TRIM_IDX 9'h102
// power-on reset hold time in ns and derived cycles
`define MOSC_POR_NS 1000
`define MOSC_POR_CYC ((`MOSC_POR_NS + `MOSC_CLK_PERIOD_NS - 1) / `MOSC_CLK_PERIOD_NS)
// relaxation oscillator start time in ns (few microseconds)
`define MOSC_ROSC_NS 2000
`define MOSC_ROSC_CYC ((`MOSC_ROSC_NS + `MOSC_CLK_PERIOD_NS - 1) / `MOSC_CLK_PERIOD_NS)
// boot sequence length in cycles
`define MOSC_BOOT_CYC 64
// 32.768 kHz tick: divider from 125 MHz, rounded down
`define MOSC_SLOW_NS 30518
`define MOSC_SLOW_CYC (`MOSC_SLOW_NS / `MOSC_CLK_PERIOD_NS)

// operating state codes
`define MOSC_ST_POR 4'h0
`define MOSC_ST_FUSE 4'h1
`define MOSC_ST_CHECK 4'h2
`define MOSC_ST_MINPWR 4'h3
`define MOSC_ST_EMUL 4'h4
`define MOSC_ST_BOOT 4'h5
`define MOSC_ST_RUN 4'h6
`define MOSC_ST_IDLE 4'h7
`define MOSC_ST_DOZE 4'h8
`define MOSC_ST_WAKE 4'h9
`define MOSC_ST_SNIFF 4'hA

`endif

// >>> logic/mosc_pin_sync.v
/*
  three-flop synchroniser for a bundle of pins; a change is taken
  once stages two and three agree. assumes one system clock.
*/
`timescale 1ns/100ps
module mosc_pin_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input  wire             clock,
  input  wire             reset,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1_q;  // metastable stage, read only by s2
  reg [WIDTH-1:0] s2_q;  // second stage
  reg [WIDTH-1:0] s3_q;  // third stage

  // shift chain; filtered level updates only where s2 and s3 agree
  always @(posedge clock) begin
    if (reset) begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      level <= INIT;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      level <= (s2_q & s3_q) | (level & (s2_q ^ s3_q));
    end
  end
endmodule // mosc_pin_sync

// >>> logic/mosc_fuse_loader.v
/*
  fuse table loader: walks the hardware and design-specific words of
  the 2 KB fuse page and latches io direction and parameters.
  assumes a flash read port with one-cycle read latency.
*/
`timescale 1ns/100ps
`include "mosc_consts.vh"
module mosc_fuse_loader #(
  parameter AW = `MOSC_FUSE_AW
) (
  input  wire          clock,
  input  wire          reset,
  input  wire          start,
  input  wire [31:0]   rd_data,
  output reg  [AW-1:0] rd_addr,
  output reg           rd_en,
  output reg           done,
  output reg  [31:0]   io_dir,
  output reg  [31:0]   uart_mode,
  output reg  [31:0]   clk_source,
  output reg  [31:0]   trim
);
  reg [1:0] step_q;   // word being fetched
  reg       busy_q;   // sequence running
  reg       vld_q;    // read data valid this cycle

  // word index for each step
  function [AW-1:0] step_addr;
    input [1:0] s;
    begin
      case (s)
        2'h0:    step_addr = `MOSC_FUSE_IODIR_IDX;
        2'h1:    step_addr = `MOSC_FUSE_UART_IDX;
        2'h2:    step_addr = `MOSC_FUSE_CLKSRC_IDX;
        default: step_addr = `MOSC_FUSE_TRIM_IDX;
      endcase
    end
  endfunction

  // hardware structure first so io_dir latches before params; mosc_state_ctrl passes all four on together at done
  always @(posedge clock) begin
    if (reset) begin
      step_q     <= 2'h0;
      busy_q     <= 1'b0;
      vld_q      <= 1'b0;
      rd_addr    <= {AW{1'b0}};
      rd_en      <= 1'b0;
      done       <= 1'b0;
      io_dir     <= 32'h00000000;  // all inputs until loaded
      uart_mode  <= 32'h00000000;
      clk_source <= 32'h00000000;
      trim       <= 32'h00000000;
    end else begin
      done  <= 1'b0;
      rd_en <= 1'b0;
      vld_q <= rd_en;
      if (start && !busy_q) begin
        busy_q  <= 1'b1;
        step_q  <= 2'h0;
        rd_addr <= step_addr(2'h0);
        rd_en   <= 1'b1;
      end else if (busy_q && vld_q) begin
        case (step_q)
          2'h0:    io_dir     <= rd_data;
          2'h1:    uart_mode  <= rd_data;
          2'h2:    clk_source <= rd_data;
          default: trim       <= rd_data;
        endcase
        if (step_q == 2'h3) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end else begin
          step_q  <= step_q + 2'h1;
          rd_addr <= step_addr(step_q + 2'h1);
          rd_en   <= 1'b1;
        end
      end
    end
  end
endmodule // mosc_fuse_loader

// >>> logic/mosc_state_ctrl.v
/*
  mote operating state control: start-up, fuse load, flash emulation
  entry, active run/idle, doze duty cycling, forced doze and radio
  inhibit gating. assumes one 125 MHz clock, pins from outside.
*/
// Overview of operation
// - start-up on power-on reset or reset pin
// - load fuse table, io direction, after reset
// - program select with reset enters flash emulation
// - reset held without program: minimum power
// - reset released: boot, then active
// - fuse page 2 KB, hardware and design parts
// - emulation suspends normal work, acts as flash
// - cycle run, idle, doze choosing lowest power
// - active: oscillator on, peripherals on demand
// - doze only when cpu and peripherals inactive; the force doze pin takes idle or sniff to doze regardless
// - doze keeps state, wakes on io activity
// - slow oscillator and its timers run in doze
// - force doze pin holds doze until released
// - radio inhibit refuses new radio operations
// - operation in progress finishes before inhibit
// - peripherals wake to sniff, cpu only on packet
// - relaxation oscillator clocks all, starts fast
`timescale 1ns/100ps
`include "mosc_consts.vh"
module mosc_state_ctrl #(
  parameter POR_CYC  = `MOSC_POR_CYC,
  parameter ROSC_CYC = `MOSC_ROSC_CYC,
  parameter BOOT_CYC = `MOSC_BOOT_CYC,
  parameter SLOW_CYC = `MOSC_SLOW_CYC
) (
  input  wire        clock,
  input  wire        reset,            // power-on reset circuit output
  input  wire        reset_pin_low,     // external reset pin
  input  wire        program_select_pin, // active low
  input  wire        force_doze_pin,    // active low
  input  wire        timestamp_capture_pin, // active low
  input  wire        radio_inhibit_pin,  // active high
  input  wire        uart_activity,     // pin-level activity
  input  wire        cpu_busy,          // cpu wants to run
  input  wire        periph_busy,       // any peripheral active
  input  wire        sniff_due,         // slow timer asks for rf check
  input  wire        packet_seen,       // radio found a packet
  input  wire        radio_req,         // request to start radio op
  input  wire        radio_op_done,     // current radio op finished
  input  wire [31:0] fuse_rd_data,
  output reg  [8:0]  fuse_rd_addr,
  output reg         fuse_rd_en,
  output reg  [31:0] io_dir,
  output reg  [31:0] uart_mode,
  output reg  [31:0] clk_source,
  output reg  [31:0] trim,
  output reg  [3:0]  op_state,
  output reg         rosc_enable,
  output reg         rosc_ready,
  output reg         slow_osc_enable,
  output reg         slow_tick,
  output reg         cpu_clock_en,
  output reg         periph_enable,
  output reg         flash_emul_active,
  output reg         min_power,
  output reg         radio_grant,
  output reg         radio_busy
);
  // synchronised pin levels (active-low ones idle high, act_lvl low after reset)
  wire [3:0] sync_lvl;
  wire       rst_n_s  = sync_lvl[0];
  wire       prog_n_s = sync_lvl[1];
  wire       doze_n_s = sync_lvl[2];
  wire       time_n_s = sync_lvl[3];
  wire [1:0] act_lvl;               // radio inhibit, uart activity
  wire       inhibit_s = act_lvl[0];
  wire       uart_s    = act_lvl[1];

  // pins cross into the clock domain before any decision
  mosc_pin_sync #(.WIDTH(4), .INIT(4'hF)) u_sync_n (
    .clock (clock),
    .reset (reset),
    .pin   ({timestamp_capture_pin, force_doze_pin,
             program_select_pin, reset_pin_low}),
    .level (sync_lvl)
  );
  mosc_pin_sync #(.WIDTH(2), .INIT(2'h0)) u_sync_p (
    .clock (clock),
    .reset (reset),
    .pin   ({uart_activity, radio_inhibit_pin}),
    .level (act_lvl)
  );

  // fuse loader outputs
  wire [8:0]  ld_addr;
  wire        ld_en;
  wire        ld_done;
  wire [31:0] ld_iodir;
  wire [31:0] ld_uart;
  wire [31:0] ld_clk;
  wire [31:0] ld_trim;
  reg         ld_start_q;   // one-cycle start pulse

  mosc_fuse_loader #(.AW(`MOSC_FUSE_AW)) u_fuse (
    .clock      (clock),
    .reset      (reset),
    .start      (ld_start_q),
    .rd_data    (fuse_rd_data),
    .rd_addr    (ld_addr),
    .rd_en      (ld_en),
    .done       (ld_done),
    .io_dir     (ld_iodir),
    .uart_mode  (ld_uart),
    .clk_source (ld_clk),
    .trim       (ld_trim)
  );

  reg [3:0]  state_q;     // operating state
  reg [3:0]  state_d;
  reg [15:0] cnt_q;       // por / boot / wake counter
  reg [15:0] cnt_d;
  reg        rst_n_prev_q; // for falling edge of reset pin
  reg [15:0] slow_q;      // 32.768 kHz divider
  reg        fused_q;     // fuse table loaded since reset
  reg        ld_go;       // request loader start
  reg        radio_act_q; // radio op under way

  wire rst_fall = rst_n_prev_q & ~rst_n_s;
  // io activity that must wake doze: uart activity or timestamp capture pin
  wire wake_io  = uart_s | ~time_n_s;

  // edge tracker for reset pin
  always @(posedge clock) begin
    if (reset) rst_n_prev_q <= 1'b1;
    else       rst_n_prev_q <= rst_n_s;
  end

  // next-state logic
  always @* begin
    state_d = state_q;
    cnt_d   = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
    ld_go   = 1'b0;
    case (state_q)
      `MOSC_ST_POR: begin
        // wait out power-on reset, then load fuses
        if (cnt_q == 16'h0000) begin
          state_d = `MOSC_ST_FUSE;
          ld_go   = 1'b1;
        end
      end
      `MOSC_ST_FUSE: begin
        if (ld_done) state_d = `MOSC_ST_CHECK;
      end
      `MOSC_ST_CHECK: begin
        // sample program select together with reset
        if (!rst_n_s && !prog_n_s)
          state_d = `MOSC_ST_EMUL;
        else if (!rst_n_s)
          state_d = `MOSC_ST_MINPWR;
        else begin
          state_d = `MOSC_ST_BOOT;
          cnt_d   = BOOT_CYC[15:0];
        end
      end
      `MOSC_ST_MINPWR: begin
        if (rst_n_s) begin
          state_d = `MOSC_ST_BOOT;
          cnt_d   = BOOT_CYC[15:0];
        end
      end
      `MOSC_ST_EMUL: begin
        // only a reset pulse leaves emulation
        state_d = state_q;
      end
      `MOSC_ST_BOOT: begin
        if (cnt_q == 16'h0000) state_d = `MOSC_ST_RUN;
      end
      `MOSC_ST_RUN: begin
        if (!cpu_busy) state_d = `MOSC_ST_IDLE;
      end
      `MOSC_ST_IDLE: begin
        if (cpu_busy && doze_n_s)
          state_d = `MOSC_ST_RUN;
        else if (!doze_n_s || (!periph_busy && !radio_act_q))
          state_d = `MOSC_ST_DOZE;
      end
      `MOSC_ST_DOZE: begin
        // forced doze ignores all wake sources
        if (doze_n_s && (wake_io || cpu_busy)) begin
          state_d = `MOSC_ST_WAKE;
          cnt_d   = ROSC_CYC[15:0];
        end else if (doze_n_s && sniff_due && slow_tick) begin
          state_d = `MOSC_ST_SNIFF;
          cnt_d   = ROSC_CYC[15:0];
        end
      end
      `MOSC_ST_WAKE: begin
        if (cnt_q == 16'h0000) state_d = `MOSC_ST_RUN;
      end
      `MOSC_ST_SNIFF: begin
        // peripherals look for rf energy without the cpu
        if (!doze_n_s)
          state_d = `MOSC_ST_DOZE;
        else if (cnt_q == 16'h0000 && packet_seen)
          state_d = `MOSC_ST_RUN;
        else if (cnt_q == 16'h0000 && !periph_busy && !radio_act_q)
          state_d = `MOSC_ST_DOZE;
      end
      default: state_d = `MOSC_ST_POR;
    endcase
    // reset pin falling edge restarts from the fuse load
    if (rst_fall && state_q != `MOSC_ST_POR) begin
      state_d = `MOSC_ST_FUSE;
      ld_go   = 1'b1;
    end
  end

  // state register; power-on reset restarts the whole sequence
  always @(posedge clock) begin
    if (reset) begin
      state_q    <= `MOSC_ST_POR;
      cnt_q      <= POR_CYC[15:0];
      ld_start_q <= 1'b0;
      fused_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      ld_start_q <= ld_go;
      if (ld_go)        fused_q <= 1'b0;
      else if (ld_done) fused_q <= 1'b1;
    end
  end

  // 32.768 kHz tick divider, kept running in every state
  always @(posedge clock) begin
    if (reset) begin
      slow_q    <= 16'h0000;
      slow_tick <= 1'b0;
    end else if (slow_q == SLOW_CYC[15:0] - 16'h0001) begin
      slow_q    <= 16'h0000;
      slow_tick <= 1'b1;
    end else begin
      slow_q    <= slow_q + 16'h0001;
      slow_tick <= 1'b0;
    end
  end

  // radio gating: new ops refused under inhibit, running op finishes
  always @(posedge clock) begin
    if (reset) begin
      radio_act_q <= 1'b0;
      radio_grant <= 1'b0;
      radio_busy  <= 1'b0;
    end else begin
      radio_grant <= 1'b0;
      if (radio_act_q && radio_op_done) begin
        radio_act_q <= 1'b0;
        radio_busy  <= 1'b0;
      end else if (!radio_act_q && radio_req && !inhibit_s &&
                   (state_q == `MOSC_ST_RUN ||
                    state_q == `MOSC_ST_IDLE ||
                    state_q == `MOSC_ST_SNIFF)) begin
        radio_act_q <= 1'b1;
        radio_grant <= 1'b1;
        radio_busy  <= 1'b1;
      end
    end
  end

  // registered outputs: state flags from next state, fuse port and loaded values from the loader
  always @(posedge clock) begin
    if (reset) begin
      op_state          <= `MOSC_ST_POR;
      rosc_enable       <= 1'b1;
      rosc_ready        <= 1'b0;
      slow_osc_enable   <= 1'b1;
      cpu_clock_en      <= 1'b0;
      periph_enable     <= 1'b0;
      flash_emul_active <= 1'b0;
      min_power         <= 1'b0;
      fuse_rd_addr      <= 9'h000;
      fuse_rd_en        <= 1'b0;
      io_dir            <= 32'h00000000;
      uart_mode         <= 32'h00000000;
      clk_source        <= 32'h00000000;
      trim              <= 32'h00000000;
    end else begin
      op_state        <= state_d;
      slow_osc_enable <= 1'b1;
      // relaxation oscillator off only in doze and minimum power
      rosc_enable <= !(state_d == `MOSC_ST_DOZE ||
                       state_d == `MOSC_ST_MINPWR);
      rosc_ready  <= (state_d == `MOSC_ST_RUN ||
                      state_d == `MOSC_ST_IDLE ||
                      state_d == `MOSC_ST_BOOT);
      cpu_clock_en <= (state_d == `MOSC_ST_RUN ||
                       state_d == `MOSC_ST_BOOT);
      periph_enable <= (state_d == `MOSC_ST_RUN ||
                        state_d == `MOSC_ST_IDLE ||
                        state_d == `MOSC_ST_SNIFF) &&
                       (periph_busy || radio_act_q);
      flash_emul_active <= (state_d == `MOSC_ST_EMUL);
      min_power         <= (state_d == `MOSC_ST_MINPWR);
      fuse_rd_addr      <= ld_addr;
      fuse_rd_en        <= ld_en;
      // loaded values held through doze; state is retained
      if (ld_done) begin
        io_dir     <= ld_iodir;
        uart_mode  <= ld_uart;
        clk_source <= ld_clk;
        trim       <= ld_trim;
      end
    end
  end
endmodule // mosc_state_ctrl

// >>> verif/mosc_state_ctrl_monitor.sv
/*
  checker for the operating state control block: radio gating,
  doze outputs and forced hold, start-up states.
  assumes it is bound to mosc_state_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
`include "mosc_consts.vh"
module mosc_state_ctrl_monitor (
  input wire       clock,
  input wire       reset,
  input wire       reset_pin_low,
  input wire       force_doze_pin,
  input wire       radio_inhibit_pin,
  input wire       radio_req,
  input wire       radio_op_done,
  input wire [3:0] op_state,
  input wire       rosc_enable,
  input wire       slow_osc_enable,
  input wire       cpu_clock_en,
  input wire       flash_emul_active,
  input wire       min_power,
  input wire       radio_grant,
  input wire       radio_busy
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_grant_has_cause: assert property (
    radio_grant |-> $past(radio_req) && !$past(radio_busy))
    else $error("grant without request or while busy");
  a_inhibit_refuses: assert property (
    (radio_inhibit_pin)[*8] |=> !radio_grant)
    else $error("grant while inhibit held");
  a_grant_one_pulse: assert property (
    radio_grant |-> radio_busy ##1 !radio_grant)
    else $error("grant not a busy one-cycle pulse");
  a_busy_until_done: assert property (
    radio_busy && !radio_op_done |=> radio_busy)
    else $error("radio op cut short");
  a_busy_ends_done: assert property (
    radio_busy && radio_op_done |=> !radio_busy)
    else $error("busy stays after done");
  a_doze_cpu_off: assert property (
    (op_state == `MOSC_ST_DOZE)[*2] |-> !cpu_clock_en)
    else $error("cpu clock on in doze");
  a_doze_slow_osc: assert property (
    op_state == `MOSC_ST_DOZE |-> slow_osc_enable)
    else $error("slow oscillator off in doze");
  a_active_rosc_on: assert property (
    op_state == `MOSC_ST_RUN || op_state == `MOSC_ST_IDLE |-> rosc_enable)
    else $error("relaxation oscillator off while active");
  a_forced_doze_hold: assert property (
    (!force_doze_pin)[*8] ##0 op_state == `MOSC_ST_DOZE
    |=> op_state == `MOSC_ST_DOZE)
    else $error("left doze while forced");
  a_emul_suspends: assert property (
    (op_state == `MOSC_ST_EMUL)[*2] |-> flash_emul_active && !cpu_clock_en)
    else $error("emulation flags wrong");
  a_min_power_flag: assert property (
    (op_state == `MOSC_ST_MINPWR)[*2] |-> min_power)
    else $error("min power flag missing");
  a_reset_pin_stops: assert property (
    (!reset_pin_low)[*8] |-> op_state != `MOSC_ST_RUN &&
    op_state != `MOSC_ST_IDLE && op_state != `MOSC_ST_DOZE)
    else $error("operational while reset pin held");
endmodule // mosc_state_ctrl_monitor

bind mosc_state_ctrl mosc_state_ctrl_monitor u_mosc_state_ctrl_monitor (
  .clock, .reset, .reset_pin_low, .force_doze_pin, .radio_inhibit_pin,
  .radio_req, .radio_op_done, .op_state, .rosc_enable, .slow_osc_enable,
  .cpu_clock_en, .flash_emul_active, .min_power, .radio_grant, .radio_busy
);

// >>> verif/mosc_fuse_flash_model.sv
/*
  behavioural fuse page flash: shows the addressed word while the
  port read enable stands, stale data otherwise.
  assumes the loader samples data at the edge that ends that cycle.
*/
`timescale 1ns/100ps
module mosc_fuse_flash_model (
  input  wire        clock,
  input  wire        fuse_rd_en,
  input  wire [8:0]  fuse_rd_addr,
  output reg  [31:0] fuse_rd_data
);
  reg [31:0] stale_q;  // filler shown outside the read cycle
  initial stale_q = 32'h0000_0000;

  // stale data toggles so a late sample cannot pass by luck
  always @(posedge clock) begin
    stale_q <= ~stale_q;
  end

  // marker on top, word index below; index bit 8 picks the structure
  // the loader takes data in the same cycle the port enable stands
  always @* begin
    if (fuse_rd_en) begin
      fuse_rd_data = {16'hC3A5, 7'h00, fuse_rd_addr};
    end else begin
      fuse_rd_data = stale_q;
    end
  end
endmodule // mosc_fuse_flash_model

// >>> verif/tb_top.sv
/*
  self-checking bench for the operating state control block.
  assumes short count parameters and the fuse flash model.
*/
`timescale 1ns/100ps
`include "mosc_consts.vh"
`define CHK(g,e) begin tests_run = tests_run + 1; \
  if ((g) !== (e)) begin mismatches = mismatches + 1; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  reg         clock, reset, reset_pin_low, program_select_pin;
  reg         force_doze_pin, timestamp_capture_pin, radio_inhibit_pin;
  reg         uart_activity, cpu_busy, periph_busy, sniff_due;
  reg         packet_seen, radio_req, radio_op_done;
  wire [31:0] fuse_rd_data, io_dir, uart_mode, clk_source, trim;
  wire [8:0]  fuse_rd_addr;
  wire [3:0]  op_state;
  wire        fuse_rd_en, rosc_enable, slow_osc_enable, cpu_clock_en;
  wire        flash_emul_active, min_power, radio_grant, radio_busy;
  integer     mismatches, tests_run;

  // short counts keep the run small
  mosc_state_ctrl #(.POR_CYC(4), .ROSC_CYC(4), .BOOT_CYC(4),
    .SLOW_CYC(16)) u_mosc_state_ctrl (
    .clock, .reset, .reset_pin_low, .program_select_pin, .force_doze_pin,
    .timestamp_capture_pin, .radio_inhibit_pin, .uart_activity, .cpu_busy,
    .periph_busy, .sniff_due, .packet_seen, .radio_req, .radio_op_done,
    .fuse_rd_data, .fuse_rd_addr, .fuse_rd_en, .io_dir, .uart_mode,
    .clk_source, .trim, .op_state, .rosc_enable, .rosc_ready(),
    .slow_osc_enable, .slow_tick(), .cpu_clock_en, .periph_enable(),
    .flash_emul_active, .min_power, .radio_grant, .radio_busy);

  mosc_fuse_flash_model u_mosc_fuse_flash_model (
    .clock, .fuse_rd_en, .fuse_rd_addr, .fuse_rd_data);

  always #4 clock = ~clock;

  // expected fuse word for an index
  function [31:0] fw(input [8:0] a);
    fw = {16'hC3A5, 7'h00, a};
  endfunction

  // inputs move 1 ns after the edge
  task step(input integer n);
    begin repeat (n) @(posedge clock); #1; end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask

  // bounded wait for op_state to equal (eq=1) or leave (eq=0) st
  task wait_op(input [3:0] st, input eq);
    integer i;
    begin
      i = 0;
      while ((op_state === st) !== eq && i < 2000) begin
        step(1);
        i = i + 1;
      end
      `CHK(op_state === st, eq)
      if ((op_state === st) !== eq) tally_and_finish;
    end
  endtask

  task t_boot;
    begin
      wait_op(`MOSC_ST_RUN, 1'b1);
      `CHK(io_dir, fw(9'h000))
      `CHK(uart_mode, fw(9'h100))
      `CHK(clk_source, fw(9'h101))
      `CHK(trim, fw(9'h102))
      `CHK(rosc_enable, 1'b1)
      $display("done boot");
    end
  endtask

  task t_radio;
    begin
      radio_req = 1'b1;
      step(1);
      `CHK({radio_grant, radio_busy}, 2'h3)
      step(1);
      `CHK(radio_grant, 1'b0)
      radio_req = 1'b0;
      radio_inhibit_pin = 1'b1;
      step(8);
      `CHK(radio_busy, 1'b1)
      radio_op_done = 1'b1;
      step(1);
      radio_op_done = 1'b0;
      `CHK(radio_busy, 1'b0)
      radio_req = 1'b1;
      repeat (3) begin step(1); `CHK(radio_grant, 1'b0) end
      radio_req = 1'b0;
      radio_inhibit_pin = 1'b0;
      step(8);
      radio_req = 1'b1;
      step(1);
      `CHK(radio_grant, 1'b1)
      radio_req = 1'b0;
      radio_op_done = 1'b1;
      step(1);
      radio_op_done = 1'b0;
      $display("done radio");
    end
  endtask

  task t_doze;
    begin
      cpu_busy = 1'b0;
      periph_busy = 1'b1;
      step(40);
      `CHK(op_state === `MOSC_ST_DOZE, 1'b0)
      periph_busy = 1'b0;
      wait_op(`MOSC_ST_DOZE, 1'b1);
      `CHK(slow_osc_enable, 1'b1)
      timestamp_capture_pin = 1'b0;
      wait_op(`MOSC_ST_DOZE, 1'b0);
      timestamp_capture_pin = 1'b1;
      wait_op(`MOSC_ST_DOZE, 1'b1);
      uart_activity = 1'b1;
      wait_op(`MOSC_ST_DOZE, 1'b0);
      uart_activity = 1'b0;
      wait_op(`MOSC_ST_DOZE, 1'b1);
      $display("done doze");
    end
  endtask

  task t_sniff;
    begin
      sniff_due = 1'b1;
      wait_op(`MOSC_ST_SNIFF, 1'b1);
      sniff_due = 1'b0;
      `CHK(cpu_clock_en, 1'b0)
      wait_op(`MOSC_ST_DOZE, 1'b1);
      sniff_due = 1'b1;
      wait_op(`MOSC_ST_SNIFF, 1'b1);
      sniff_due = 1'b0;
      packet_seen = 1'b1;
      wait_op(`MOSC_ST_SNIFF, 1'b0);
      packet_seen = 1'b0;
      `CHK(op_state === `MOSC_ST_DOZE, 1'b0)
      cpu_busy = 1'b1;
      wait_op(`MOSC_ST_RUN, 1'b1);
      $display("done sniff");
    end
  endtask

  task t_force;
    begin
      force_doze_pin = 1'b0;
      cpu_busy = 1'b0;
      wait_op(`MOSC_ST_DOZE, 1'b1);
      uart_activity = 1'b1;
      step(40);
      `CHK(op_state, `MOSC_ST_DOZE)
      force_doze_pin = 1'b1;
      wait_op(`MOSC_ST_DOZE, 1'b0);
      uart_activity = 1'b0;
      cpu_busy = 1'b1;
      wait_op(`MOSC_ST_RUN, 1'b1);
      $display("done force");
    end
  endtask

  task t_pins;
    begin
      // a one-cycle glitch must be filtered by the synchroniser
      reset_pin_low = 1'b0;
      step(1);
      reset_pin_low = 1'b1;
      step(20);
      `CHK(op_state, `MOSC_ST_RUN)
      reset_pin_low = 1'b0;
      wait_op(`MOSC_ST_MINPWR, 1'b1);
      step(2);
      `CHK(min_power, 1'b1)
      reset_pin_low = 1'b1;
      wait_op(`MOSC_ST_RUN, 1'b1);
      `CHK(io_dir, fw(9'h000))
      program_select_pin = 1'b0;
      reset_pin_low = 1'b0;
      wait_op(`MOSC_ST_EMUL, 1'b1);
      step(2);
      `CHK({flash_emul_active, cpu_clock_en}, 2'h2)
      // power reset during flash emulation restarts from scratch
      reset = 1'b1;
      program_select_pin = 1'b1;
      reset_pin_low = 1'b1;
      step(2);
      `CHK(op_state, `MOSC_ST_POR)
      reset = 1'b0;
      wait_op(`MOSC_ST_RUN, 1'b1);
      $display("done pins");
    end
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    reset_pin_low = 1'b1;
    program_select_pin = 1'b1;
    force_doze_pin = 1'b1;
    timestamp_capture_pin = 1'b1;
    radio_inhibit_pin = 1'b0;
    uart_activity = 1'b0;
    cpu_busy = 1'b1;
    periph_busy = 1'b0;
    sniff_due = 1'b0;
    packet_seen = 1'b0;
    radio_req = 1'b0;
    radio_op_done = 1'b0;
    mismatches = 0;
    tests_run = 0;
    step(16);
    reset = 1'b0;
    t_boot;
    t_radio;
    t_doze;
    t_sniff;
    t_force;
    t_pins;
    tally_and_finish;
  end
endmodule // tb_top
